// ==== logic/host_ram_pointer_config_params.svh ====
// offsets, field positions, reset values for the host ram pointer / config register group
// assumes an 8-bit register port with 3-bit offsets chosen locally
`ifndef HOST_RAM_POINTER_CONFIG_PARAMS_SVH
`define HOST_RAM_POINTER_CONFIG_PARAMS_SVH
`define OFS_RAM_POINTER_HIGH     3'h2
`define OFS_RAM_POINTER_LOW      3'h3
`define OFS_DEVICE_CONFIGURATION 3'h6
`define OFS_INDIRECT_SELECT      3'h5
`define OFS_ENGINE_STATUS        3'h0
`define BIT_READ_PREFETCH        7
`define BIT_POINTER_AUTOINCREMENT              6
`define BIT_SOFT_RESET           7
`define BIT_CMD_QUEUE            6
`define BIT_TX_ENABLE            5
`define BIT_BACKPLANE            2
`define RST_CONFIG               8'h00
`define RST_SELECT               3'h0
`define RST_POINTER              11'h000
`endif

// ==== logic/host_ram_pointer_config_pkg.sv ====
// types shared by the register group
// assumes the params header is compiled alongside
package host_ram_pointer_config_pkg;
  typedef enum logic [2:0] {
    sel_tentative_id = 3'b000,
    sel_node_id      = 3'b001,
    sel_setup_one    = 3'b010,
    sel_next_id      = 3'b011,
    sel_setup_two    = 3'b100
  } indirect_sel_e;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } host_req_s;
endpackage

// ==== logic/host_ram_pointer_config_regs.sv ====
// register group: ram pointer, indirect select and device configuration
// assumes a same-clock host port and a ram data port that pulses ram_access
// What this block does
// [RULE1] Pointer high bit 7 announces whether the next ram access is a read (1) or a write (0).
// [RULE2] With pointer high bit 6 set the ram pointer advances by one after each data access.
// [RULE3] The host writes zeros to the undefined bits of pointer high and the select register.
// [RULE4] Pointer high bits 2-0 give ram address bits 10 to 8.
// [RULE5] Pointer low bits 7-0 give ram address bits 7 to 0.
// [RULE6] The three select bits choose which indirect register shows at address 07.
// [RULE7] The two low select bits are also config bits 1,0 and both write the same selector.
// [RULE8] Config bit 7 holds the device in soft reset until written back to zero.
// [RULE9] Soft reset leaves config and interface mode alone and clears only status, next id, diagnostics.
// [RULE10] Config bit 6 enables command chaining; low keeps the older non-chaining behaviour.
// [RULE11] With config bit 5 low the line driver enable, and pulses outside backplane mode, stay inactive.
// [RULE12] The transmit enable bit clears on the hard reset only; a soft reset leaves it set.
// [RULE13] The host sets transmit enable once the node id is known and leaves it set.
// [RULE14] Auto-increment wraps the 11-bit pointer from its top address to zero and reads back updated.
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`include "host_ram_pointer_config_params.svh"
module host_ram_pointer_config_regs
  import host_ram_pointer_config_pkg::*;
#(
  parameter int ADDR_W = 11
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic [2:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  input  wire logic              ram_access,
  input  wire logic [7:0]        engine_status,
  input  wire logic              eng_tx_active,
  input  wire logic              eng_pulse_one,
  input  wire logic              eng_pulse_two,
  output logic      [ADDR_W-1:0] ram_addr,
  output logic                   read_prefetch_select,
  output logic      [2:0]        indirect_reg_select,
  output logic                   soft_reset,
  output logic                   command_queue_enable,
  output logic                   line_driver_enable_n,
  output logic                   line_pulse_one_n,
  output logic                   line_pulse_two_n
);

  // ==========================================================
  // register state
  host_req_s         req;
  logic [ADDR_W-1:0] pointer_reg;
  logic [1:0]        ptr_mode_reg;
  logic [7:0]        config_reg;
  logic [2:0]        select_reg;
  logic              tx_en;
  logic              backplane;

  assign req       = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign tx_en     = config_reg[`BIT_TX_ENABLE];
  assign backplane = config_reg[`BIT_BACKPLANE];

  function automatic logic hit(input logic [2:0] a, input logic [2:0] ofs);
    hit = (a == ofs);
  endfunction

  // ==========================================================
  // pointer: host writes take priority over an increment in the same cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pointer_reg  <= `RST_POINTER;
      ptr_mode_reg <= 2'h0;
    end else if (req.wr && hit(req.addr, `OFS_RAM_POINTER_HIGH)) begin
      ptr_mode_reg <= {req.wdata[`BIT_READ_PREFETCH], req.wdata[`BIT_POINTER_AUTOINCREMENT]}; // RULE1
      pointer_reg  <= {req.wdata[2:0], pointer_reg[7:0]}; // RULE4
    end else if (req.wr && hit(req.addr, `OFS_RAM_POINTER_LOW)) begin
      pointer_reg <= {pointer_reg[ADDR_W-1:8], req.wdata}; // RULE5
    end else if (ram_access && ptr_mode_reg[0]) begin
      pointer_reg <= pointer_reg + 1'b1; // RULE2 RULE14
    end
  end

  // ==========================================================
  // configuration and selector; only the hard reset touches these
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      config_reg <= `RST_CONFIG; // RULE12
    end else if (req.wr && hit(req.addr, `OFS_DEVICE_CONFIGURATION)) begin
      config_reg <= req.wdata; // RULE8 RULE9 RULE10
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      select_reg <= `RST_SELECT;
    end else if (req.wr && hit(req.addr, `OFS_INDIRECT_SELECT)) begin
      select_reg <= req.wdata[2:0]; // RULE6
    end else if (req.wr && hit(req.addr, `OFS_DEVICE_CONFIGURATION)) begin
      select_reg <= {select_reg[2], req.wdata[1:0]}; // RULE7
    end
  end

  // ==========================================================
  // outputs, all registered
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ram_addr             <= `RST_POINTER;
      read_prefetch_select <= 1'b0;
      indirect_reg_select  <= `RST_SELECT;
      soft_reset           <= 1'b0;
      command_queue_enable <= 1'b0;
    end else begin
      ram_addr             <= pointer_reg;
      read_prefetch_select <= ptr_mode_reg[1]; // RULE1
      indirect_reg_select  <= select_reg; // RULE6
      soft_reset           <= config_reg[`BIT_SOFT_RESET]; // RULE8
      command_queue_enable <= config_reg[`BIT_CMD_QUEUE]; // RULE10
    end
  end

  // the gate is kept even in backplane mode for the driver enable
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      line_driver_enable_n <= 1'b1;
      line_pulse_one_n     <= 1'b1;
      line_pulse_two_n     <= 1'b1;
    end else begin
      line_driver_enable_n <= ~(tx_en & eng_tx_active); // RULE11
      line_pulse_one_n     <= ~((tx_en | backplane) & eng_pulse_one); // RULE11
      line_pulse_two_n     <= ~((tx_en | backplane) & eng_pulse_two); // RULE11
    end
  end

  // ==========================================================
  // read port: data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        `OFS_RAM_POINTER_HIGH:     reg_rdata <= {ptr_mode_reg, 3'b000, pointer_reg[10:8]};
        `OFS_RAM_POINTER_LOW:      reg_rdata <= pointer_reg[7:0]; // RULE14
        `OFS_INDIRECT_SELECT:      reg_rdata <= {5'h00, select_reg};
        `OFS_DEVICE_CONFIGURATION: reg_rdata <= {config_reg[7:2], select_reg[1:0]}; // RULE7
        `OFS_ENGINE_STATUS:        reg_rdata <= engine_status;
        default:                   reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ==========================================================
  // checks
  property p_pointer_autoincrement;
    @(posedge clk_sys) disable iff (rst)
    (ram_access && ptr_mode_reg[0] && !req.wr) |=> (pointer_reg == $past(pointer_reg) + 1'b1);
  endproperty
  a_pointer_autoincrement: assert property (p_pointer_autoincrement) else $error("pointer did not advance"); // RULE2

  property p_hold;
    @(posedge clk_sys) disable iff (rst)
    (ram_access && !ptr_mode_reg[0] && !req.wr) |=> $stable(pointer_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("pointer moved without pointer_autoincrement"); // RULE2

  property p_wrap;
    @(posedge clk_sys) disable iff (rst)
    (ram_access && ptr_mode_reg[0] && !req.wr && pointer_reg == 11'h7ff) |=> (pointer_reg == 11'h000);
  endproperty
  a_wrap: assert property (p_wrap) else $error("pointer did not wrap"); // RULE14

  property p_addr_out;
    @(posedge clk_sys) disable iff (rst)
    (req.wr && hit(req.addr, `OFS_RAM_POINTER_LOW)) |=> ##1 (ram_addr[7:0] == $past(req.wdata, 2));
  endproperty
  a_addr_out: assert property (p_addr_out) else $error("low address not driven"); // RULE5

  property p_high_out;
    @(posedge clk_sys) disable iff (rst)
    (req.wr && hit(req.addr, `OFS_RAM_POINTER_HIGH)) |=> ##1
      (ram_addr[10:8] == $past(req.wdata[2:0], 2) && read_prefetch_select == $past(req.wdata[7], 2));
  endproperty
  a_high_out: assert property (p_high_out) else $error("high address or direction wrong"); // RULE4

  property p_sel_mirror;
    @(posedge clk_sys) disable iff (rst)
    (req.wr && hit(req.addr, `OFS_DEVICE_CONFIGURATION)) |=> ##1 (indirect_reg_select[1:0] == $past(req.wdata[1:0], 2));
  endproperty
  a_sel_mirror: assert property (p_sel_mirror) else $error("config write missed selector"); // RULE7

  property p_txoff;
    @(posedge clk_sys) disable iff (rst)
    (!tx_en) |=> line_driver_enable_n;
  endproperty
  a_txoff: assert property (p_txoff) else $error("driver enabled with transmit off"); // RULE11

  property p_softrst;
    @(posedge clk_sys) disable iff (rst)
    (req.wr && hit(req.addr, `OFS_DEVICE_CONFIGURATION) && req.wdata[7]) |=> ##1 soft_reset;
  endproperty
  a_softrst: assert property (p_softrst) else $error("soft reset not raised"); // RULE8

  property p_cfg_kept;
    @(posedge clk_sys) disable iff (rst)
    (soft_reset && !(req.wr && hit(req.addr, `OFS_DEVICE_CONFIGURATION))) |=> $stable(config_reg);
  endproperty
  a_cfg_kept: assert property (p_cfg_kept) else $error("config changed in soft reset"); // RULE9

  property p_chain;
    @(posedge clk_sys) disable iff (rst)
    1'b1 |=> (command_queue_enable == $past(config_reg[6]));
  endproperty
  a_chain: assert property (p_chain) else $error("chaining enable wrong"); // RULE10

  // ==========================================================
  // read port and selector checks, built from the host strobe steps, then line driver and pulse checks
  sequence s_wr_select;
    req.wr && hit(req.addr, `OFS_INDIRECT_SELECT);
  endsequence

  sequence s_rd_high;
    req.rd && hit(req.addr, `OFS_RAM_POINTER_HIGH);
  endsequence

  sequence s_rd_low;
    req.rd && hit(req.addr, `OFS_RAM_POINTER_LOW);
  endsequence

  property p_sel_write;
    @(posedge clk_sys) disable iff (rst)
    s_wr_select |=> ##1 (indirect_reg_select == $past(req.wdata[2:0], 2));
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("select write not applied"); // RULE6

  property p_rd_high;
    @(posedge clk_sys) disable iff (rst)
    s_rd_high |=> (reg_rdata[2:0] == $past(pointer_reg[10:8]) && reg_rdata[5:3] == 3'h0);
  endproperty
  a_rd_high: assert property (p_rd_high) else $error("pointer high read wrong"); // RULE4

  property p_rd_low;
    @(posedge clk_sys) disable iff (rst)
    s_rd_low |=> (reg_rdata == $past(pointer_reg[7:0]));
  endproperty
  a_rd_low: assert property (p_rd_low) else $error("pointer low read wrong"); // RULE5

  // read data must not linger: a stale byte would be taken for a second read
  property p_rd_idle;
    @(posedge clk_sys) disable iff (rst)
    !req.rd |=> (reg_rdata == 8'h00);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot"); // RULE5

  property p_pulse_gate;
    @(posedge clk_sys) disable iff (rst)
    (!tx_en && !backplane) |=> (line_pulse_one_n && line_pulse_two_n);
  endproperty
  a_pulse_gate: assert property (p_pulse_gate) else $error("pulse active with transmit off"); // RULE11

  property p_txon;
    @(posedge clk_sys) disable iff (rst)
    (tx_en && eng_tx_active) |=> !line_driver_enable_n;
  endproperty
  a_txon: assert property (p_txon) else $error("driver not enabled on request"); // RULE11

endmodule // host_ram_pointer_config_regs

// ==== tb/host_bus_model.sv ====
// host side model: single-cycle register port master
// assumes the caller waits out the write-to-output latency itself
`timescale 1ns/10ps
`include "host_ram_pointer_config_params.svh"
module host_bus_model (
  input  wire logic       clk_sys,
  output logic      [2:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  // ==========
  // bus cycles
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
  task automatic bus_write(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= (a == `OFS_RAM_POINTER_HIGH) ? (d & 8'hc7) :
                 (a == `OFS_INDIRECT_SELECT) ? (d & 8'h07) : d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // read data are taken one settle step into the cycle after the strobe
  task automatic bus_read(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
endmodule // host_bus_model

// ==== tb/host_ram_pointer_config_regs_test.sv ====
// self-checking bench for the ram pointer / config register group
// assumes host_bus_model drives the register port
`timescale 1ns/10ps
`include "host_ram_pointer_config_params.svh"
module host_ram_pointer_config_regs_test import host_ram_pointer_config_pkg::*;;
  logic        clk_sys, rst, ram_access, eng_tx_active, eng_pulse_one, eng_pulse_two;
  logic        reg_wr, reg_rd, read_prefetch_select, soft_reset, command_queue_enable;
  logic        line_driver_enable_n, line_pulse_one_n, line_pulse_two_n;
  logic [2:0]  reg_addr, indirect_reg_select;
  logic [7:0]  reg_wdata, reg_rdata, engine_status, rd;
  logic [10:0] ram_addr;
  int          fail_count = 0;
  int          check_count = 0;
  int          cycles = 0;
  host_bus_model host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
                       .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  host_ram_pointer_config_regs dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ram_access(ram_access),
    .engine_status(engine_status), .eng_tx_active(eng_tx_active), .eng_pulse_one(eng_pulse_one),
    .eng_pulse_two(eng_pulse_two), .ram_addr(ram_addr), .read_prefetch_select(read_prefetch_select),
    .indirect_reg_select(indirect_reg_select), .soft_reset(soft_reset),
    .command_queue_enable(command_queue_enable), .line_driver_enable_n(line_driver_enable_n),
    .line_pulse_one_n(line_pulse_one_n), .line_pulse_two_n(line_pulse_two_n));
  // ==========
  // helpers
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic chk_out(input logic [10:0] got, input logic [10:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_reg(input logic [2:0] a, input logic [7:0] exp);
    host.bus_read(a, rd);
    chk_out(11'(rd), 11'(exp));
  endtask
  task automatic wr_settle(input logic [2:0] a, input logic [7:0] d);
    host.bus_write(a, d);
    @(posedge clk_sys);
    #1;
  endtask
  // one access pulse, then one more edge for ram_addr to follow the pointer
  task automatic pulse_access();
    @(posedge clk_sys);
    ram_access <= 1'b1;
    @(posedge clk_sys);
    ram_access <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ==========
  // scenarios
  task automatic test_reset();
    chk_reg(`OFS_DEVICE_CONFIGURATION, 8'h00);
    chk_out({line_driver_enable_n, line_pulse_one_n, line_pulse_two_n}, 11'h7);
    chk_reg(3'h1, 8'h00);
    chk_reg(`OFS_ENGINE_STATUS, 8'ha5);
  endtask
  task automatic test_pointer();
    host.bus_write(`OFS_RAM_POINTER_HIGH, 8'h45);
    wr_settle(`OFS_RAM_POINTER_LOW, 8'hff);
    chk_out(ram_addr, 11'h5ff);
    chk_out(11'(read_prefetch_select), 11'h0);
    chk_reg(`OFS_RAM_POINTER_HIGH, 8'h45);
    host.bus_write(`OFS_RAM_POINTER_HIGH, 8'hc7);
    pulse_access();
    chk_out(ram_addr, 11'h000);
    chk_out(11'(read_prefetch_select), 11'h1);
    chk_reg(`OFS_RAM_POINTER_HIGH, 8'hc0);
    pulse_access();
    chk_out(ram_addr, 11'h001);
    host.bus_write(`OFS_RAM_POINTER_HIGH, 8'h81);
    pulse_access();
    chk_out(ram_addr, 11'h101);
  endtask
  task automatic test_select();
    for (int i = 0; i < 5; i++) begin
      wr_settle(`OFS_INDIRECT_SELECT, 8'(i));
      chk_out(11'(indirect_reg_select), 11'(i));
    end
    wr_settle(`OFS_DEVICE_CONFIGURATION, 8'h02);
    chk_out(11'(indirect_reg_select), 11'h6);
    chk_reg(`OFS_INDIRECT_SELECT, 8'h06);
  endtask
  task automatic test_config();
    wr_settle(`OFS_DEVICE_CONFIGURATION, 8'hc1);
    chk_out(11'({soft_reset, command_queue_enable}), 11'h3);
    chk_reg(`OFS_DEVICE_CONFIGURATION, 8'hc1);
    chk_out(ram_addr, 11'h101);
    wr_settle(`OFS_DEVICE_CONFIGURATION, 8'h40);
    chk_out(11'({soft_reset, command_queue_enable}), 11'h1);
    wr_settle(`OFS_DEVICE_CONFIGURATION, 8'h00);
    chk_out(11'(command_queue_enable), 11'h0);
  endtask
  task automatic test_tx();
    wr_settle(`OFS_DEVICE_CONFIGURATION, 8'h20);
    chk_out({line_driver_enable_n, line_pulse_one_n, line_pulse_two_n}, 11'h0);
    wr_settle(`OFS_DEVICE_CONFIGURATION, 8'h04);
    chk_out({line_driver_enable_n, line_pulse_one_n, line_pulse_two_n}, 11'h4);
    wr_settle(`OFS_DEVICE_CONFIGURATION, 8'h20);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    chk_reg(`OFS_DEVICE_CONFIGURATION, 8'h00);
    chk_out(11'(line_driver_enable_n), 11'h1);
  endtask
  initial begin
    {rst, ram_access} = 2'b10;
    {eng_tx_active, eng_pulse_one, eng_pulse_two} = 3'b111;
    engine_status = 8'ha5;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    test_reset();
    test_pointer();
    test_select();
    test_config();
    test_tx();
    test_done();
  end
endmodule // host_ram_pointer_config_regs_test
